// *** rtl/dsc_consts.vh ***
// Constants for the drive status and control register bank
`ifndef DSC_CONSTS_VH
`define DSC_CONSTS_VH
`define DSC_NREQ         8
`define DSC_RQ_MODE_RD   0
`define DSC_RQ_RAM_RD    1
`define DSC_RQ_NV_RD     2
`define DSC_RQ_MODE_WR   3
`define DSC_RQ_RAM_WR    4
`define DSC_RQ_NV_WR     5
`define DSC_RQ_ALM_CLR   6
`define DSC_RQ_PRM_CLR   7
`define DSC_MODE_NET     16'h0000
`define DSC_MODE_EXT     16'h0001
`define DSC_MODE_PU      16'h0002
`define DSC_MODE_RST     16'h0001
`define DSC_SEL_NONE     16'h0000
`define DSC_SEL_EXT      16'h0001
`define DSC_SEL_PU       16'h0002
`define DSC_SEL_PU3      16'h0003
`define DSC_SEL_PU4      16'h0004
`define DSC_FREQ_RST     16'h0000
`define DSC_FREQ_MAX     16'h2EE0
`define DSC_FREQ_STEP    16'h000A
`define DSC_ALM_KEY      16'h9696
`define DSC_PCLR_ALL     16'h9696
`define DSC_PCLR_ALL_T   16'h9966
`define DSC_PCLR_NC      16'h5A5A
`define DSC_PCLR_NC_T    16'h55AA
`define DSC_WP_LOCKED    16'h0001
`define DSC_ACC_OK       16'h0000
`define DSC_ACC_ERR      16'hFFFF
`define DSC_DIAG_RST     16'h0000
`define DSC_DIAG_INSTR   16'h000A
`define DSC_DIAG_PARAM   16'h000B
`define DSC_DIAG_WDT     16'h0016
`define DSC_DIAG_NOEND   16'h0018
`define DSC_FAULT_NONE   8'h00
`define DSC_CLK_NS       10
`define DSC_FLICKER_CYC  25'd25000000
`define DSC_FLK_W        25
`endif

// *** rtl/dsc_handshake.v ***
// Command / completion handshake for all read and write requests
`timescale 1ns/1ps
`include "dsc_consts.vh"
module dsc_handshake (
  input  wire                     i_core_clk,
  input  wire                     i_rstn,
  input  wire                     i_hold,
  input  wire [`DSC_NREQ-1:0]     i_req,
  input  wire [`DSC_NREQ-1:0]     i_finish,
  output wire [`DSC_NREQ-1:0]     o_start,
  output reg  [`DSC_NREQ-1:0]     o_busy_r,
  output reg  [`DSC_NREQ-1:0]     o_done_r
);
  reg [`DSC_NREQ-1:0] req_d_r;

  // Only a fresh rising edge starts work; a held command does nothing
  assign o_start = i_req & ~req_d_r & ~o_busy_r & ~o_done_r & {`DSC_NREQ{~i_hold}};

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      req_d_r  <= {`DSC_NREQ{1'b0}};
      o_busy_r <= {`DSC_NREQ{1'b0}};
      o_done_r <= {`DSC_NREQ{1'b0}};
    end else begin
      req_d_r  <= i_req;
      o_busy_r <= (o_busy_r | o_start) & ~i_finish;
      // Done rises with completion, falls with the command
      o_done_r <= (o_done_r | (o_busy_r & i_finish)) & i_req;
    end
  end
endmodule // dsc_handshake

// *** rtl/dsc_fault_hist.v ***
// Eight-deep fault code history with batch clear
`timescale 1ns/1ps
`include "dsc_consts.vh"
module dsc_fault_hist (
  input  wire        i_core_clk,
  input  wire        i_rstn,
  input  wire        i_push,
  input  wire [7:0]  i_code,
  input  wire        i_clear,
  output reg         o_clear_done_r,
  output wire [15:0] o_pair_1_2,
  output wire [15:0] o_pair_3_4,
  output wire [15:0] o_pair_5_6,
  output wire [15:0] o_pair_7_8
);
  reg [7:0] hist_r [0:7];
  integer   k;
  wire      push_ok;

  // Code zero means no alarm, so it is never recorded
  assign push_ok = i_push && (i_code != `DSC_FAULT_NONE);

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      for (k = 0; k < 8; k = k + 1)
        hist_r[k] <= `DSC_FAULT_NONE;
      o_clear_done_r <= 1'b0;
    end else begin
      o_clear_done_r <= i_clear;
      for (k = 7; k > 0; k = k - 1) begin
        if (i_clear)
          hist_r[k] <= `DSC_FAULT_NONE;
        else if (push_ok)
          hist_r[k] <= hist_r[k-1];
      end
      // A fault arriving with the clear survives it
      if (push_ok)
        hist_r[0] <= i_code;
      else if (i_clear)
        hist_r[0] <= `DSC_FAULT_NONE;
    end
  end

  // Even entry high byte, odd entry low byte; entry 1 is newest
  assign o_pair_1_2 = {hist_r[1], hist_r[0]};
  assign o_pair_3_4 = {hist_r[3], hist_r[2]};
  assign o_pair_5_6 = {hist_r[5], hist_r[4]};
  assign o_pair_7_8 = {hist_r[7], hist_r[6]};
endmodule // dsc_fault_hist

// *** rtl/dsc_top.v ***
// Drive status monitoring and control register bank
`timescale 1ns/1ps
`include "dsc_consts.vh"
module dsc_top #(
  parameter [`DSC_FLK_W-1:0] FLICKER_CYC = `DSC_FLICKER_CYC
) (
  input  wire        i_core_clk,
  input  wire        i_rstn,
  input  wire        i_scan_end,
  input  wire [15:0] i_out_freq,
  input  wire [15:0] i_out_curr,
  input  wire [15:0] i_out_volt,
  input  wire        i_fault_valid,
  input  wire [7:0]  i_fault_code,
  input  wire        i_drive_running,
  input  wire [15:0] i_mode_selection_parameter,
  input  wire [15:0] i_write_protect_parameter,
  input  wire        i_mode_read_request,
  input  wire        i_ram_freq_read_request,
  input  wire        i_nv_freq_read_request,
  input  wire        i_mode_write_request,
  input  wire        i_ram_freq_write_request,
  input  wire        i_nv_freq_write_request,
  input  wire        i_alarm_clear_request,
  input  wire        i_param_clear_request,
  input  wire [15:0] i_operation_mode_write,
  input  wire [15:0] i_set_frequency_volatile_write,
  input  wire [15:0] i_set_frequency_nonvolatile_write,
  input  wire [15:0] i_alarm_history_clear,
  input  wire [15:0] i_parameter_clear,
  input  wire        i_param_clear_finished,
  input  wire        i_err_param,
  input  wire        i_err_watchdog,
  input  wire        i_err_no_end,
  input  wire        i_op_check,
  input  wire        i_op_basic,
  input  wire        i_op_exec_cond,
  input  wire        i_op_bad,
  output wire        o_mode_read_done,
  output wire        o_ram_freq_read_done,
  output wire        o_nv_freq_read_done,
  output wire        o_mode_write_done,
  output wire        o_ram_freq_write_done,
  output wire        o_nv_freq_write_done,
  output wire        o_alarm_clear_done,
  output wire        o_param_clear_done,
  output reg  [15:0] o_output_frequency_monitor,
  output reg  [15:0] o_output_current_monitor,
  output reg  [15:0] o_output_voltage_monitor,
  output reg  [15:0] o_fault_history_pair_1_2,
  output reg  [15:0] o_fault_history_pair_3_4,
  output reg  [15:0] o_fault_history_pair_5_6,
  output reg  [15:0] o_fault_history_pair_last,
  output reg  [15:0] o_operation_mode_readback,
  output reg  [15:0] o_set_frequency_volatile_readback,
  output reg  [15:0] o_set_frequency_nonvolatile_readback,
  output reg  [15:0] o_access_error_register,
  output reg  [15:0] o_self_diag_error_number,
  output reg         o_run_led,
  output reg         o_program_outputs_clear,
  output reg  [15:0] o_operation_mode,
  output reg  [15:0] o_ram_set_freq,
  output reg  [15:0] o_applied_freq,
  output reg  [15:0] o_nv_set_freq,
  output reg         o_param_clear_start,
  output reg  [15:0] o_param_clear_code
);

  function [15:0] eff_mode;
    input [15:0] sel;
    input [15:0] cur;
    begin
      if (sel == `DSC_SEL_NONE)
        eff_mode = cur;
      else if (sel == `DSC_SEL_PU3 || sel == `DSC_SEL_PU4)
        eff_mode = `DSC_MODE_PU;
      else if (sel == `DSC_SEL_EXT)
        eff_mode = `DSC_MODE_EXT;
      else if (sel == `DSC_SEL_PU)
        eff_mode = `DSC_MODE_PU;
      else
        eff_mode = cur;
    end
  endfunction

  function freq_ok;
    input [15:0] data;
    input [15:0] mode;
    begin
      freq_ok = (data <= `DSC_FREQ_MAX) &&
                (mode == `DSC_MODE_PU || mode == `DSC_MODE_NET);
    end
  endfunction

  function pclr_key;
    input [15:0] data;
    begin
      pclr_key = (data == `DSC_PCLR_ALL) || (data == `DSC_PCLR_ALL_T) ||
                 (data == `DSC_PCLR_NC) || (data == `DSC_PCLR_NC_T);
    end
  endfunction

  wire [`DSC_NREQ-1:0] req;
  wire [`DSC_NREQ-1:0] start;
  wire [`DSC_NREQ-1:0] busy;
  wire [`DSC_NREQ-1:0] done;
  reg  [`DSC_NREQ-1:0] finish;
  reg  [`DSC_NREQ-1:0] bad_r;
  reg  [`DSC_NREQ-1:0] ok_nxt;
  wire [`DSC_NREQ-1:0] fin_eff;
  wire [15:0]          mode_now;
  wire                 sel_writable;
  wire                 hold;
  wire                 clr_done;
  reg                  hist_clr_r;
  wire [15:0]          pair_1_2;
  wire [15:0]          pair_3_4;
  wire [15:0]          pair_5_6;
  wire [15:0]          pair_7_8;
  wire                 instr_err;
  wire                 any_err;
  reg  [15:0]          diag_nxt;
  reg  [`DSC_FLK_W-1:0] flk_cnt_r;
  wire                 flk_tick;

  assign req = {i_param_clear_request, i_alarm_clear_request,
                i_nv_freq_write_request, i_ram_freq_write_request,
                i_mode_write_request, i_nv_freq_read_request,
                i_ram_freq_read_request, i_mode_read_request};

  // After an error stop no new command starts and outputs freeze until reset, except the run light and done flags
  assign hold         = o_program_outputs_clear;
  assign mode_now     = eff_mode(i_mode_selection_parameter, o_operation_mode);
  assign sel_writable = (i_mode_selection_parameter == `DSC_SEL_NONE) ||
                        (i_mode_selection_parameter == `DSC_SEL_PU);

  assign o_mode_read_done      = done[`DSC_RQ_MODE_RD];
  assign o_ram_freq_read_done  = done[`DSC_RQ_RAM_RD];
  assign o_nv_freq_read_done   = done[`DSC_RQ_NV_RD];
  assign o_mode_write_done     = done[`DSC_RQ_MODE_WR];
  assign o_ram_freq_write_done = done[`DSC_RQ_RAM_WR];
  assign o_nv_freq_write_done  = done[`DSC_RQ_NV_WR];
  assign o_alarm_clear_done    = done[`DSC_RQ_ALM_CLR];
  assign o_param_clear_done    = done[`DSC_RQ_PRM_CLR];

  dsc_handshake u_hs (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_hold     (hold),
    .i_req      (req),
    .i_finish   (finish),
    .o_start    (start),
    .o_busy_r   (busy),
    .o_done_r   (done)
  );

  dsc_fault_hist u_hist (
    .i_core_clk     (i_core_clk),
    .i_rstn         (i_rstn),
    .i_push         (i_fault_valid),
    .i_code         (i_fault_code),
    .i_clear        (hist_clr_r),
    .o_clear_done_r (clr_done),
    .o_pair_1_2     (pair_1_2),
    .o_pair_3_4     (pair_3_4),
    .o_pair_5_6     (pair_5_6),
    .o_pair_7_8     (pair_7_8)
  );

  // Validity of each write, judged when its command rises
  always @* begin
    ok_nxt = {`DSC_NREQ{1'b1}};
    ok_nxt[`DSC_RQ_MODE_WR] = (i_operation_mode_write <= `DSC_MODE_PU) &&
                              !i_drive_running && sel_writable;
    ok_nxt[`DSC_RQ_RAM_WR]  = freq_ok(i_set_frequency_volatile_write, mode_now);
    ok_nxt[`DSC_RQ_NV_WR]   = freq_ok(i_set_frequency_nonvolatile_write, mode_now);
    ok_nxt[`DSC_RQ_ALM_CLR] = (i_alarm_history_clear == `DSC_ALM_KEY) &&
                              !i_drive_running;
    ok_nxt[`DSC_RQ_PRM_CLR] = pclr_key(i_parameter_clear) && !i_drive_running &&
                              (i_write_protect_parameter != `DSC_WP_LOCKED) &&
                              (mode_now == `DSC_MODE_PU ||
                               mode_now == `DSC_MODE_NET);
  end

  // Accepted clears finish on the clearing logic, refused clears and other work one cycle after start
  always @* begin
    finish = busy;
    finish[`DSC_RQ_ALM_CLR] = busy[`DSC_RQ_ALM_CLR] &
                              (bad_r[`DSC_RQ_ALM_CLR] | clr_done);
    finish[`DSC_RQ_PRM_CLR] = busy[`DSC_RQ_PRM_CLR] &
                              (bad_r[`DSC_RQ_PRM_CLR] | i_param_clear_finished);
  end

  // Completion edge, as the handshake module will see it
  assign fin_eff = busy & finish & req;

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      bad_r                <= {`DSC_NREQ{1'b0}};
      hist_clr_r           <= 1'b0;
      o_param_clear_start  <= 1'b0;
      o_param_clear_code   <= `DSC_PCLR_ALL;
      o_operation_mode     <= `DSC_MODE_RST;
      o_ram_set_freq       <= `DSC_FREQ_RST;
      o_nv_set_freq        <= `DSC_FREQ_RST;
      o_applied_freq       <= `DSC_FREQ_RST;
    end else begin
      hist_clr_r          <= 1'b0;
      o_param_clear_start <= 1'b0;
      // Coarse step: drive only resolves 0.1 Hz
      o_applied_freq <= o_ram_set_freq - (o_ram_set_freq % `DSC_FREQ_STEP);
      if (!hold) begin
        bad_r <= (bad_r & ~start) | (start & ~ok_nxt);
        // Writes take effect at start, done follows next cycle
        if (start[`DSC_RQ_MODE_WR] && ok_nxt[`DSC_RQ_MODE_WR])
          o_operation_mode <= i_operation_mode_write;
        if (start[`DSC_RQ_RAM_WR] && ok_nxt[`DSC_RQ_RAM_WR])
          o_ram_set_freq <= i_set_frequency_volatile_write;
        if (start[`DSC_RQ_NV_WR] && ok_nxt[`DSC_RQ_NV_WR])
          o_nv_set_freq <= i_set_frequency_nonvolatile_write;
        if (start[`DSC_RQ_ALM_CLR] && ok_nxt[`DSC_RQ_ALM_CLR])
          hist_clr_r <= 1'b1;
        if (start[`DSC_RQ_PRM_CLR] && ok_nxt[`DSC_RQ_PRM_CLR]) begin
          o_param_clear_start <= 1'b1;
          o_param_clear_code  <= i_parameter_clear;
        end
      end
    end
  end

  // Read data and access error land on the completion edge
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_operation_mode_readback            <= `DSC_MODE_RST;
      o_set_frequency_volatile_readback    <= `DSC_FREQ_RST;
      o_set_frequency_nonvolatile_readback <= `DSC_FREQ_RST;
      o_access_error_register              <= `DSC_ACC_OK;
    end else if (!hold) begin
      if (fin_eff[`DSC_RQ_MODE_RD])
        o_operation_mode_readback <= mode_now;
      if (fin_eff[`DSC_RQ_RAM_RD])
        o_set_frequency_volatile_readback <= o_ram_set_freq;
      if (fin_eff[`DSC_RQ_NV_RD])
        o_set_frequency_nonvolatile_readback <= o_nv_set_freq;
      if (|(fin_eff & ~bad_r & 8'hF8))
        o_access_error_register <= `DSC_ACC_OK;
      if (|(fin_eff & bad_r & 8'hF8))
        o_access_error_register <= `DSC_ACC_ERR;
    end
  end

  // Monitors and history follow the scan, not the drive's own rate
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_output_frequency_monitor <= 16'h0000;
      o_output_current_monitor   <= 16'h0000;
      o_output_voltage_monitor   <= 16'h0000;
      o_fault_history_pair_1_2   <= 16'h0000;
      o_fault_history_pair_3_4   <= 16'h0000;
      o_fault_history_pair_5_6   <= 16'h0000;
      o_fault_history_pair_last  <= 16'h0000;
    end else if (i_scan_end && !hold) begin
      o_output_frequency_monitor <= i_out_freq;
      o_output_current_monitor   <= i_out_curr;
      o_output_voltage_monitor   <= i_out_volt;
      o_fault_history_pair_1_2   <= pair_1_2;
      o_fault_history_pair_3_4   <= pair_3_4;
      o_fault_history_pair_5_6   <= pair_5_6;
      o_fault_history_pair_last  <= pair_7_8;
    end
  end

  // Basic and execution-condition instructions are checked only while i_op_check is set
  assign instr_err = i_op_check && i_op_bad && (i_op_basic || i_op_exec_cond);
  assign any_err   = instr_err || i_err_param || i_err_watchdog || i_err_no_end;

  always @* begin
    if (instr_err)
      diag_nxt = `DSC_DIAG_INSTR;
    else if (i_err_param)
      diag_nxt = `DSC_DIAG_PARAM;
    else if (i_err_watchdog)
      diag_nxt = `DSC_DIAG_WDT;
    else
      diag_nxt = `DSC_DIAG_NOEND;
  end

  assign flk_tick = (flk_cnt_r == FLICKER_CYC - 1'b1);

  // First error wins; later ones are not recorded during the stop
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_self_diag_error_number <= `DSC_DIAG_RST;
      o_program_outputs_clear  <= 1'b0;
      o_run_led                <= 1'b1;
      flk_cnt_r                <= {`DSC_FLK_W{1'b0}};
    end else begin
      if (any_err && !hold) begin
        o_self_diag_error_number <= diag_nxt;
        o_program_outputs_clear  <= 1'b1;
      end
      if (!hold) begin
        flk_cnt_r <= {`DSC_FLK_W{1'b0}};
        o_run_led <= 1'b1;
      end else if (flk_tick) begin
        flk_cnt_r <= {`DSC_FLK_W{1'b0}};
        o_run_led <= ~o_run_led;
      end else begin
        flk_cnt_r <= flk_cnt_r + 1'b1;
      end
    end
  end

endmodule // dsc_top

// *** verification/dsc_top_props.sv ***
// Concurrent checks on the ports of the drive status and control register bank
`timescale 1ns/1ps
`include "dsc_consts.vh"
module dsc_top_props #(
  parameter [`DSC_FLK_W-1:0] FLICKER_CYC = 4
) (
  input wire        i_core_clk,
  input wire        i_rstn,
  input wire        i_scan_end,
  input wire [15:0] i_out_freq,
  input wire        i_mode_read_request,
  input wire [15:0] i_mode_selection_parameter,
  input wire [15:0] i_set_frequency_volatile_write,
  input wire        i_err_param,
  input wire        o_mode_read_done,
  input wire        o_ram_freq_write_done,
  input wire [15:0] o_output_frequency_monitor,
  input wire [15:0] o_operation_mode_readback,
  input wire [15:0] o_ram_set_freq,
  input wire [15:0] o_applied_freq,
  input wire [15:0] o_access_error_register,
  input wire [15:0] o_self_diag_error_number,
  input wire        o_run_led,
  input wire        o_program_outputs_clear
);
  // Two cycles of slack above the half period
  localparam int FLK_WIN = FLICKER_CYC + 2;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_read_done_lat: assert property ($rose(i_mode_read_request) && !o_mode_read_done
    && !o_program_outputs_clear |-> ##[2:3] o_mode_read_done) else $error("read done late");
  a_read_hold: assert property (!$rose(o_mode_read_done)
    |-> $stable(o_operation_mode_readback)) else $error("mode readback moved without done");
  a_mode_enc: assert property ($rose(o_mode_read_done)
    && i_mode_selection_parameter inside {[16'h0001:16'h0004]}
    |-> o_operation_mode_readback == (i_mode_selection_parameter == 16'h0001 ? 16'h0001
    : 16'h0002)) else $error("mode readback encoding wrong");
  a_freq_refuse: assert property ($rose(o_ram_freq_write_done)
    && i_set_frequency_volatile_write > `DSC_FREQ_MAX |-> o_access_error_register == 16'hFFFF
    && o_ram_set_freq == $past(o_ram_set_freq, 3)) else $error("bad frequency accepted");
  a_applied_step: assert property (o_applied_freq == $past(o_ram_set_freq)
    - $past(o_ram_set_freq) % 16'h000A) else $error("applied frequency not in 0.1 Hz steps");
  a_mon_refresh: assert property (i_scan_end && !o_program_outputs_clear
    |=> o_output_frequency_monitor == $past(i_out_freq)) else $error("monitor not refreshed");
  a_diag_param: assert property (i_err_param && !o_program_outputs_clear
    |=> o_self_diag_error_number == 16'h000B && o_program_outputs_clear)
    else $error("parameter error not recorded");
  a_led_steady: assert property (!o_program_outputs_clear |-> o_run_led)
    else $error("run light not steady");
  a_led_flicker: assert property (o_program_outputs_clear
    |-> ##[1:FLK_WIN] $changed(o_run_led)) else $error("run light not flickering");
  a_done_drop: assert property (o_mode_read_done && !i_mode_read_request
    && !o_program_outputs_clear |-> ##[1:2] !o_mode_read_done) else $error("done stuck");
endmodule // dsc_top_props
bind dsc_top dsc_top_props #(.FLICKER_CYC(FLICKER_CYC)) u_dsc_top_props (.*);

// *** verification/dsc_prog_model.sv ***
// Sequence program model: raises one command, waits for completion, drops it
`timescale 1ns/1ps
module dsc_prog_model (
  input  wire       i_core_clk,
  input  wire [7:0] i_done,
  output reg  [7:0] o_req
);
  initial o_req = 8'h00;
  // One channel at a time; hold keeps the command up after completion
  task xfer(input int ch, input int hold, output bit ok);
    int n;
    begin
      ok = 1'b0;
      @(negedge i_core_clk);
      o_req[ch] = 1'b1;
      for (n = 0; n < 40 && !ok; n++) begin
        @(posedge i_core_clk);
        #1 ok = (i_done[ch] === 1'b1);
      end
      repeat (hold) @(posedge i_core_clk);
      @(negedge i_core_clk);
      o_req[ch] = 1'b0;
      repeat (2) @(negedge i_core_clk);
    end
  endtask
endmodule // dsc_prog_model

// *** verification/test_dsc_top.sv ***
// Self-checking bench for the drive status and control register bank
`timescale 1ns/1ps
`include "dsc_consts.vh"
module test_dsc_top;
  reg i_core_clk = 1'b0;
  reg i_rstn, i_scan_end, i_fault_valid, i_drive_running, i_param_clear_finished;
  reg i_err_param, i_err_watchdog, i_err_no_end, i_op_check, i_op_basic, i_op_exec_cond;
  reg i_op_bad, last;
  reg [7:0] i_fault_code;
  reg [15:0] i_out_freq, i_out_curr, i_out_volt, i_mode_selection_parameter;
  reg [15:0] i_write_protect_parameter, i_operation_mode_write, i_set_frequency_volatile_write;
  reg [15:0] i_set_frequency_nonvolatile_write, i_alarm_history_clear, i_parameter_clear;
  wire [7:0] req, done;
  wire i_mode_read_request = req[`DSC_RQ_MODE_RD];
  wire i_ram_freq_read_request = req[`DSC_RQ_RAM_RD];
  wire i_nv_freq_read_request = req[`DSC_RQ_NV_RD];
  wire i_mode_write_request = req[`DSC_RQ_MODE_WR];
  wire i_ram_freq_write_request = req[`DSC_RQ_RAM_WR];
  wire i_nv_freq_write_request = req[`DSC_RQ_NV_WR];
  wire i_alarm_clear_request = req[`DSC_RQ_ALM_CLR];
  wire i_param_clear_request = req[`DSC_RQ_PRM_CLR];
  wire o_mode_read_done, o_ram_freq_read_done, o_nv_freq_read_done, o_mode_write_done;
  wire o_ram_freq_write_done, o_nv_freq_write_done, o_alarm_clear_done, o_param_clear_done;
  wire o_run_led, o_program_outputs_clear, o_param_clear_start;
  wire [15:0] o_output_frequency_monitor, o_output_current_monitor, o_output_voltage_monitor;
  wire [15:0] o_fault_history_pair_1_2, o_fault_history_pair_3_4, o_fault_history_pair_5_6;
  wire [15:0] o_fault_history_pair_last, o_operation_mode_readback, o_access_error_register;
  wire [15:0] o_set_frequency_volatile_readback, o_set_frequency_nonvolatile_readback;
  wire [15:0] o_self_diag_error_number, o_operation_mode, o_ram_set_freq, o_applied_freq;
  wire [15:0] o_nv_set_freq, o_param_clear_code;
  int i, k, n, err_count, n_compared;
  reg [7:0] codes [8] = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31};
  reg [2:0] ev [6] = '{3'b010, 3'b001, 3'b100, 3'b000, 3'b000, 3'b000};
  reg [3:0] ov [6] = '{4'h0, 4'h0, 4'h0, 4'b1101, 4'b1011, 4'b1001};
  reg [15:0] dx [6] = '{`DSC_DIAG_WDT, `DSC_DIAG_PARAM, `DSC_DIAG_NOEND, `DSC_DIAG_INSTR,
                       `DSC_DIAG_INSTR, `DSC_DIAG_RST};
  assign done = {o_param_clear_done, o_alarm_clear_done, o_nv_freq_write_done,
                 o_ram_freq_write_done, o_mode_write_done, o_nv_freq_read_done,
                 o_ram_freq_read_done, o_mode_read_done};
  dsc_top #(.FLICKER_CYC(25'd4)) u_dsc_top (.*);
  dsc_prog_model u_dsc_prog_model (.i_core_clk(i_core_clk), .i_done(done), .o_req(req));
  always #5 i_core_clk = ~i_core_clk;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task op(input int ch, input [15:0] d);
    bit ok;
    begin
      @(negedge i_core_clk);
      case (ch)
        3: i_operation_mode_write = d;
        4: i_set_frequency_volatile_write = d;
        5: i_set_frequency_nonvolatile_write = d;
        6: i_alarm_history_clear = d;
        7: i_parameter_clear = d;
        default: ;
      endcase
      u_dsc_prog_model.xfer(ch, 0, ok);
      chk(16'(ok), 16'h0001);
    end
  endtask
  task rst;
    begin
      @(negedge i_core_clk);
      i_rstn = 1'b0;
      repeat (3) @(negedge i_core_clk);
      i_rstn = 1'b1;
    end
  endtask
  task scan;
    begin
      @(negedge i_core_clk);
      i_scan_end = 1'b1;
      @(negedge i_core_clk);
      i_scan_end = 1'b0;
      @(negedge i_core_clk);
    end
  endtask
  task push(input [7:0] c);
    begin
      @(negedge i_core_clk);
      i_fault_code = c;
      i_fault_valid = 1'b1;
      @(negedge i_core_clk);
      i_fault_valid = 1'b0;
    end
  endtask
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Watchdog at about seventy times the expected run
  initial begin
    #200000;
    err_count = err_count + 1;
    conclude;
  end
  initial begin
    {i_rstn, i_scan_end, i_fault_valid, i_drive_running, i_param_clear_finished} = '0;
    {i_err_param, i_err_watchdog, i_err_no_end, i_op_check, i_op_basic} = '0;
    {i_op_exec_cond, i_op_bad, i_fault_code, i_out_freq, i_out_curr, i_out_volt} = '0;
    {i_mode_selection_parameter, i_write_protect_parameter, i_operation_mode_write} = '0;
    {i_set_frequency_volatile_write, i_set_frequency_nonvolatile_write} = '0;
    {i_alarm_history_clear, i_parameter_clear, err_count, n_compared} = '0;
    rst;
    chk(o_operation_mode_readback, `DSC_MODE_RST);
    chk(o_param_clear_code, `DSC_PCLR_ALL);
    $display("test reset done");
    {i_out_freq, i_out_curr, i_out_volt} = {16'h1770, 16'h00C8, 16'h03E8};
    scan;
    chk(o_output_frequency_monitor, 16'h1770);
    chk(o_output_current_monitor, 16'h00C8);
    chk(o_output_voltage_monitor, 16'h03E8);
    i_out_freq = 16'h0BB8;
    repeat (3) @(negedge i_core_clk);
    chk(o_output_frequency_monitor, 16'h1770);
    for (i = 0; i < 8; i++) push(codes[i]);
    push(`DSC_FAULT_NONE);
    scan;
    chk(o_fault_history_pair_1_2, 16'h3031);
    chk(o_fault_history_pair_3_4, 16'h2122);
    chk(o_fault_history_pair_5_6, 16'h1220);
    chk(o_fault_history_pair_last, 16'h1011);
    $display("test monitors done");
    for (i = 0; i < 5; i++) begin
      i_mode_selection_parameter = 16'(i);
      op(`DSC_RQ_MODE_RD, 16'h0000);
      chk(o_operation_mode_readback, i < 2 ? `DSC_MODE_EXT : `DSC_MODE_PU);
    end
    fork
      u_dsc_prog_model.xfer(`DSC_RQ_MODE_RD, 8, last);
      begin
        repeat (6) @(negedge i_core_clk);
        i_mode_selection_parameter = `DSC_SEL_EXT;
      end
    join
    chk(o_operation_mode_readback, `DSC_MODE_PU);
    $display("test mode read done");
    i_mode_selection_parameter = `DSC_SEL_PU;
    op(`DSC_RQ_RAM_WR, 16'h1775);
    chk(o_access_error_register, `DSC_ACC_OK);
    chk(o_applied_freq, 16'h1770);
    op(`DSC_RQ_RAM_WR, `DSC_FREQ_MAX);
    op(`DSC_RQ_RAM_WR, 16'h2EE1);
    chk(o_access_error_register, `DSC_ACC_ERR);
    op(`DSC_RQ_NV_WR, 16'h03E8);
    chk(o_nv_set_freq, 16'h03E8);
    op(`DSC_RQ_RAM_RD, 16'h0000);
    chk(o_set_frequency_volatile_readback, `DSC_FREQ_MAX);
    op(`DSC_RQ_NV_RD, 16'h0000);
    chk(o_set_frequency_nonvolatile_readback, 16'h03E8);
    i_mode_selection_parameter = `DSC_SEL_EXT;
    op(`DSC_RQ_RAM_WR, 16'h0064);
    chk(o_access_error_register, `DSC_ACC_ERR);
    chk(o_ram_set_freq, `DSC_FREQ_MAX);
    $display("test frequency done");
    i_mode_selection_parameter = `DSC_SEL_NONE;
    op(`DSC_RQ_MODE_WR, `DSC_MODE_NET);
    chk(o_operation_mode, `DSC_MODE_NET);
    op(`DSC_RQ_MODE_WR, 16'h0003);
    chk(o_access_error_register, `DSC_ACC_ERR);
    i_drive_running = 1'b1;
    op(`DSC_RQ_MODE_WR, `DSC_MODE_PU);
    chk(o_operation_mode, `DSC_MODE_NET);
    i_drive_running = 1'b0;
    op(`DSC_RQ_MODE_RD, 16'h0000);
    chk(o_operation_mode_readback, `DSC_MODE_NET);
    $display("test mode write done");
    op(`DSC_RQ_ALM_CLR, 16'h1234);
    chk(o_access_error_register, `DSC_ACC_ERR);
    scan;
    chk(o_fault_history_pair_last, 16'h1011);
    op(`DSC_RQ_ALM_CLR, `DSC_ALM_KEY);
    chk(o_access_error_register, `DSC_ACC_OK);
    scan;
    chk(o_fault_history_pair_1_2 | o_fault_history_pair_last, 16'h0000);
    i_write_protect_parameter = `DSC_WP_LOCKED;
    op(`DSC_RQ_PRM_CLR, `DSC_PCLR_NC);
    chk(o_access_error_register, `DSC_ACC_ERR);
    i_write_protect_parameter = 16'h0000;
    fork
      op(`DSC_RQ_PRM_CLR, `DSC_PCLR_NC);
      begin
        for (k = 0; k < 20; k++) begin
          @(posedge i_core_clk);
          #1 if (o_param_clear_start === 1'b1) break;
        end
        chk(o_param_clear_code, `DSC_PCLR_NC);
        repeat (4) @(negedge i_core_clk);
        chk(16'(o_param_clear_done), 16'h0000);
        i_param_clear_finished = 1'b1;
        @(negedge i_core_clk);
        i_param_clear_finished = 1'b0;
      end
    join
    chk(o_access_error_register, `DSC_ACC_OK);
    $display("test clears done");
    for (i = 0; i < 6; i++) begin
      rst;
      {i_err_no_end, i_err_watchdog, i_err_param} = ev[i];
      {i_op_check, i_op_basic, i_op_exec_cond, i_op_bad} = ov[i];
      @(negedge i_core_clk);
      {i_err_no_end, i_err_watchdog, i_err_param, i_op_check, i_op_bad} = '0;
      i_out_freq = 16'(i + 1);
      scan;
      chk(o_self_diag_error_number, dx[i]);
      chk(o_output_frequency_monitor, dx[i] != 16'h0000 ? 16'h0000 : 16'(i + 1));
      chk(16'(o_program_outputs_clear), 16'(dx[i] != 16'h0000));
      n = 0;
      last = o_run_led;
      for (k = 0; k < 12; k++) begin
        @(negedge i_core_clk);
        if (o_run_led !== last) n++;
        last = o_run_led;
      end
      chk(16'(n >= 2), 16'(dx[i] != 16'h0000));
    end
    $display("test errors done");
    conclude;
  end
endmodule // test_dsc_top
